// [rtl/nvc_pkg.sv]
// Purpose: Shared constants and types for the flash controller configuration block
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
package nvc_pkg;

  // Register byte offsets
  localparam logic [7:0] NVC_OFS_CONTROL = 8'h04;
  localparam logic [7:0] NVC_OFS_GEOMETRY = 8'h08;
  localparam logic [7:0] NVC_OFS_IRQ_EN_CLR = 8'h0c;
  localparam logic [7:0] NVC_OFS_IRQ_EN_SET = 8'h10;
  localparam logic [7:0] NVC_OFS_IRQ_FLAGS = 8'h14;

  // Control word field positions
  localparam int NVC_CACHE_OFF_BIT = 18;
  localparam int NVC_MISS_LSB = 16;
  localparam int NVC_SLEEP_LSB = 8;
  localparam int NVC_EXPLICIT_BIT = 7;
  localparam int NVC_RWS_LSB = 1;

  // Geometry word field positions
  localparam int NVC_EEP_LSB = 20;
  localparam int NVC_PSZ_LSB = 16;
  localparam int NVC_MAIN_LSB = 0;

  // Interrupt enable and flag bit positions
  localparam int NVC_IRQ_ERR_BIT = 1;
  localparam int NVC_IRQ_RDY_BIT = 0;

  // Values after reset
  localparam logic [3:0] NVC_RWS_RESET = 4'h0;
  localparam logic [1:0] NVC_IRQ_EN_RESET = 2'h0;
  localparam logic [31:0] NVC_RDATA_RESET = 32'h0;

  // Cycles a bus access is held off before it completes
  localparam int NVC_BUS_WAIT_CYCLES = 1;

  typedef enum logic [1:0] {
    NVC_MISS_FAST = 2'h0,
    NVC_MISS_LOW_POWER = 2'h1,
    NVC_MISS_EQUAL_TIME = 2'h2,
    NVC_MISS_RESERVED = 2'h3
  } nvc_miss_t;

  typedef enum logic [1:0] {
    NVC_SLEEP_WAKE_FIRST = 2'h0,
    NVC_SLEEP_WAKE_EXIT = 2'h1,
    NVC_SLEEP_RESERVED = 2'h2,
    NVC_SLEEP_NO_CUT = 2'h3
  } nvc_sleep_t;

  typedef enum logic {
    NVC_FETCH_IDLE = 1'b0,
    NVC_FETCH_WAIT = 1'b1
  } nvc_fetch_state_t;

endpackage

// [rtl/nvc_wait_if.sv]
// Purpose: Carries a wait-state request between the sequencer and its timer
// Assumes: Same clock on both ends
// Notes: start is a one-cycle pulse, done is combinational
`timescale 1ns/10ps
interface nvc_wait_if;
  logic start;
  logic [4:0] cycles;
  logic busy;
  logic done;

  modport owner (
    output start,
    output cycles,
    input busy,
    input done
  );

  modport timer (
    input start,
    input cycles,
    output busy,
    output done
  );
endinterface

// [rtl/nvc_wait_timer.sv]
// Purpose: Counts wait states for one flash fetch
// Assumes: start only while not busy and with cycles above zero
// Notes: done rises exactly cycles minus one clocks after the start edge
`timescale 1ns/10ps
module nvc_wait_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Request from the sequencer
  nvc_wait_if.timer wt
);
  import nvc_pkg::*;

  logic [4:0] count_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= 5'h00;
    end else if (wt.start) begin
      count_q <= wt.cycles;
    end else if (count_q != 5'h00) begin
      count_q <= count_q - 5'h01;
    end
  end

  assign wt.busy = (count_q != 5'h00);
  assign wt.done = (count_q == 5'h01);
endmodule // nvc_wait_timer

// [rtl/nvc_config_top.sv]
// Purpose: Configuration, geometry and interrupt-enable registers of a flash controller
// Assumes: Avalon-MM master holds each request until waitrequest is low
// Notes: Fetch timing, sleep power cut and automatic page write are driven here
`timescale 1ns/10ps

// Contract
// - Control bit 18 set turns the cache off
// - Fast policy adds no wait on miss
// - Low-power policy adds one wait per miss
// - Equal-time policy: hits and misses take wait count
// - Code 0: cut on sleep, wake on fetch
// - Code 1: cut on sleep, wake on exit
// - Code 3: no cut; code 2 reserved
// - Auto write on last-word store when not explicit
// - Four-bit wait count, zero to fifteen
// - Wait count resets to zero
// - Unused control bits read zero
// - Geometry bits 31:20 give EEPROM page count
// - Geometry bits 18:16 give page size code
// - Geometry bits 15:0 main pages; bit 19 zero
// - Writing one to clear bit 1 drops error enable
// - Writing one to clear bit 0 drops ready enable
// - Clear and set views share enables, reset zero
// - Error flag sticky on any fault, one clears
// - Ready high when idle, low while busy
module nvc_config_top #(
  parameter int ADDR_W = 22,
  parameter logic [11:0] EEPROM_PAGES = 12'h000,
  parameter logic [2:0] PAGE_SIZE_CODE = 3'h0,
  parameter logic [15:0] MAIN_PAGES = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Instruction fetch path
  input wire logic fetch_req,
  input wire logic fetch_hit,
  output logic fetch_ack,
  // Cache control
  output logic cache_off,
  output logic cache_low_power,
  output logic [3:0] read_wait_count,
  // Sleep power reduction
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  output logic flash_low_power,
  // Page buffer stores
  input wire logic buf_store,
  input wire logic buf_last_word,
  input wire logic [ADDR_W-1:0] buf_store_addr,
  output logic auto_write_start,
  output logic [ADDR_W-1:0] auto_write_addr,
  // Command engine status and faults
  input wire logic ctrl_busy,
  input wire logic flash_fault,
  input wire logic locked_region_fault,
  input wire logic bad_command_fault,
  output logic flash_ready,
  output logic error_event,
  // Interrupt enables for the interrupt logic outside
  output logic irq_err_enable,
  output logic irq_rdy_enable
);
  import nvc_pkg::*;

  // Configuration state
  logic cache_off_q;
  nvc_miss_t miss_policy_sel_q;
  nvc_sleep_t sleep_power_cut_sel_q;
  logic explicit_write_only_q;
  logic [3:0] read_wait_count_q;
  logic [1:0] irq_enable_q;
  logic error_q;
  logic ready_q;
  logic low_power_q;
  logic auto_start_q;
  logic [ADDR_W-1:0] auto_addr_q;

  // Bus slave state
  logic done_q;
  logic [31:0] readdata_q;
  logic req;
  logic wr_go;
  logic rd_take;
  logic [31:0] rd_value;
  logic [31:0] control_word;
  logic [31:0] geometry_word;

  // Fetch sequencer state
  nvc_fetch_state_t fetch_state_q;
  nvc_fetch_state_t fetch_state_d;
  logic is_miss;
  logic [4:0] wait_need;
  logic fetch_ack_c;

  nvc_wait_if wt ();

  nvc_wait_timer u_timer (
    .clk(clk),
    .reset(reset),
    .wt(wt)
  );

  // Bus handshake: one wait cycle, then the access completes
  // A write commits only in its completing cycle, so a held request writes once
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~done_q;
  assign wr_go = avs_write & done_q;
  assign rd_take = avs_read & ~done_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= req & ~done_q;
    end
  end

  // Register views
  always_comb begin
    control_word = 32'h0;
    control_word[NVC_CACHE_OFF_BIT] = cache_off_q;
    control_word[NVC_MISS_LSB +: 2] = miss_policy_sel_q;
    control_word[NVC_SLEEP_LSB +: 2] = sleep_power_cut_sel_q;
    control_word[NVC_EXPLICIT_BIT] = explicit_write_only_q;
    control_word[NVC_RWS_LSB +: 4] = read_wait_count_q;
  end

  always_comb begin
    geometry_word = 32'h0;
    geometry_word[NVC_EEP_LSB +: 12] = EEPROM_PAGES;
    geometry_word[NVC_PSZ_LSB +: 3] = PAGE_SIZE_CODE;
    geometry_word[NVC_MAIN_LSB +: 16] = MAIN_PAGES;
  end

  always_comb begin
    rd_value = 32'h0;
    unique case (avs_address)
      NVC_OFS_CONTROL: rd_value = control_word;
      NVC_OFS_GEOMETRY: rd_value = geometry_word;
      NVC_OFS_IRQ_EN_CLR: rd_value = {30'h0, irq_enable_q};
      NVC_OFS_IRQ_EN_SET: rd_value = {30'h0, irq_enable_q};
      NVC_OFS_IRQ_FLAGS: rd_value = {30'h0, error_q, ready_q};
      default: rd_value = 32'h0;
    endcase
  end

  // Read data is captured in the held-off cycle and stands at completion
  always_ff @(posedge clk) begin
    if (reset) begin
      readdata_q <= NVC_RDATA_RESET;
    end else if (rd_take) begin
      readdata_q <= rd_value;
    end
  end

  assign avs_readdata = readdata_q;

  // Control word writes; geometry offset has no write path
  always_ff @(posedge clk) begin
    if (reset) begin
      cache_off_q <= 1'b0;
      miss_policy_sel_q <= NVC_MISS_FAST;
      sleep_power_cut_sel_q <= NVC_SLEEP_WAKE_FIRST;
      explicit_write_only_q <= 1'b0;
      read_wait_count_q <= NVC_RWS_RESET;
    end else if (wr_go && avs_address == NVC_OFS_CONTROL) begin
      if (avs_byteenable[2]) begin
        cache_off_q <= avs_writedata[NVC_CACHE_OFF_BIT];
        // Reserved policy code would leave fetch timing undefined
        if (avs_writedata[NVC_MISS_LSB +: 2] != NVC_MISS_RESERVED) begin
          miss_policy_sel_q <= nvc_miss_t'(avs_writedata[NVC_MISS_LSB +: 2]);
        end
      end
      if (avs_byteenable[1]) begin
        if (avs_writedata[NVC_SLEEP_LSB +: 2] != NVC_SLEEP_RESERVED) begin
          sleep_power_cut_sel_q <= nvc_sleep_t'(avs_writedata[NVC_SLEEP_LSB +: 2]);
        end
      end
      if (avs_byteenable[0]) begin
        explicit_write_only_q <= avs_writedata[NVC_EXPLICIT_BIT];
        read_wait_count_q <= avs_writedata[NVC_RWS_LSB +: 4];
      end
    end
  end

  // Interrupt enables: one state behind the clear and set views
  // Only lane zero carries enable bits; the upper lanes are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_enable_q <= NVC_IRQ_EN_RESET;
    end else if (wr_go && avs_byteenable[0]) begin
      if (avs_address == NVC_OFS_IRQ_EN_CLR) begin
        irq_enable_q[NVC_IRQ_ERR_BIT] <= irq_enable_q[NVC_IRQ_ERR_BIT]
          & ~avs_writedata[NVC_IRQ_ERR_BIT];
        irq_enable_q[NVC_IRQ_RDY_BIT] <= irq_enable_q[NVC_IRQ_RDY_BIT]
          & ~avs_writedata[NVC_IRQ_RDY_BIT];
      end else if (avs_address == NVC_OFS_IRQ_EN_SET) begin
        irq_enable_q <= irq_enable_q | avs_writedata[1:0];
      end
    end
  end

  assign irq_err_enable = irq_enable_q[NVC_IRQ_ERR_BIT];
  assign irq_rdy_enable = irq_enable_q[NVC_IRQ_RDY_BIT];

  // Error flag: a fault in the clearing cycle still sets it
  always_ff @(posedge clk) begin
    if (reset) begin
      error_q <= 1'b0;
    end else if (flash_fault | locked_region_fault | bad_command_fault) begin
      error_q <= 1'b1;
    end else if (wr_go && avs_address == NVC_OFS_IRQ_FLAGS && avs_byteenable[0]
        && avs_writedata[NVC_IRQ_ERR_BIT]) begin
      error_q <= 1'b0;
    end
  end

  assign error_event = error_q;

  // Ready follows the command engine one cycle late
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ~ctrl_busy;
    end
  end

  assign flash_ready = ready_q;

  // Sleep power cut
  // Entering sleep wins over a same-cycle exit or fetch, so no cut is lost
  always_ff @(posedge clk) begin
    if (reset) begin
      low_power_q <= 1'b0;
    end else if (sleep_enter && sleep_power_cut_sel_q != NVC_SLEEP_NO_CUT) begin
      low_power_q <= 1'b1;
    end else if (sleep_exit && sleep_power_cut_sel_q == NVC_SLEEP_WAKE_EXIT) begin
      low_power_q <= 1'b0;
    end else if (fetch_req && sleep_power_cut_sel_q == NVC_SLEEP_WAKE_FIRST) begin
      low_power_q <= 1'b0;
    end
  end

  assign flash_low_power = low_power_q;

  // Automatic page write; the latest store address is kept for the command
  always_ff @(posedge clk) begin
    if (reset) begin
      auto_start_q <= 1'b0;
    end else begin
      auto_start_q <= buf_store & buf_last_word & ~explicit_write_only_q;
    end
  end

  // A store short of the last word moves the address only
  always_ff @(posedge clk) begin
    if (reset) begin
      auto_addr_q <= '0;
    end else if (buf_store) begin
      auto_addr_q <= buf_store_addr;
    end
  end

  assign auto_write_start = auto_start_q;
  assign auto_write_addr = auto_addr_q;

  // Cache controls
  assign cache_off = cache_off_q;
  assign cache_low_power = ~cache_off_q && miss_policy_sel_q == NVC_MISS_LOW_POWER;
  assign read_wait_count = read_wait_count_q;

  // Wait states for the fetch now requested
  // Policy code 3 is never stored, so the default arm only guards an illegal code
  assign is_miss = ~fetch_hit | cache_off_q;

  always_comb begin
    wait_need = 5'h00;
    unique case (miss_policy_sel_q)
      NVC_MISS_FAST: begin
        wait_need = is_miss ? {1'b0, read_wait_count_q} : 5'h00;
      end
      NVC_MISS_LOW_POWER: begin
        wait_need = is_miss ? {1'b0, read_wait_count_q} + 5'h01 : 5'h00;
      end
      NVC_MISS_EQUAL_TIME: begin
        wait_need = {1'b0, read_wait_count_q};
      end
      default: begin
        wait_need = is_miss ? {1'b0, read_wait_count_q} : 5'h00;
      end
    endcase
  end

  // Fetch sequencer
  always_comb begin
    fetch_state_d = fetch_state_q;
    fetch_ack_c = 1'b0;
    wt.start = 1'b0;
    wt.cycles = wait_need;
    unique case (fetch_state_q)
      NVC_FETCH_IDLE: begin
        // Timer is idle here; the guard keeps a stray start from reloading it
        if (fetch_req && !wt.busy) begin
          if (wait_need == 5'h00) begin
            fetch_ack_c = 1'b1;
          end else begin
            wt.start = 1'b1;
            fetch_state_d = NVC_FETCH_WAIT;
          end
        end
      end
      NVC_FETCH_WAIT: begin
        // The acknowledge ends the wait even if the request has since dropped
        if (wt.done) begin
          fetch_ack_c = 1'b1;
          fetch_state_d = NVC_FETCH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_state_q <= NVC_FETCH_IDLE;
    end else begin
      fetch_state_q <= fetch_state_d;
    end
  end

  assign fetch_ack = fetch_ack_c;
endmodule // nvc_config_top

// [tb/nvc_config_props.sv]
// Purpose: Port-level checks for the flash configuration block
// Assumes: Bound to every nvc_config_top instance
// Notes: Shadows sleep code and write mode from accepted bus writes
`timescale 1ns/10ps
module nvc_config_props
  import nvc_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Fetch and cache
  input wire logic fetch_req,
  input wire logic fetch_hit,
  input wire logic fetch_ack,
  input wire logic cache_off,
  input wire logic cache_low_power,
  input wire logic [3:0] read_wait_count,
  // Sleep and page buffer
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic flash_low_power,
  input wire logic buf_store,
  input wire logic buf_last_word,
  input wire logic [ADDR_W-1:0] buf_store_addr,
  input wire logic auto_write_start,
  input wire logic [ADDR_W-1:0] auto_write_addr,
  // Status and enables
  input wire logic ctrl_busy,
  input wire logic flash_fault,
  input wire logic locked_region_fault,
  input wire logic bad_command_fault,
  input wire logic flash_ready,
  input wire logic error_event,
  input wire logic irq_err_enable,
  input wire logic irq_rdy_enable
);
  logic [1:0] sleep_q;
  logic manual_q;
  wire acc = avs_write & ~avs_waitrequest;
  wire ctl_wr = acc & (avs_address == NVC_OFS_CONTROL);
  wire clr_wr = acc & (avs_address == NVC_OFS_IRQ_EN_CLR);
  // Reserved sleep code leaves the field alone, so the shadow skips it too
  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_q <= 2'h0;
    end else if (ctl_wr && avs_byteenable[1] && avs_writedata[9:8] != 2'h2) begin
      sleep_q <= avs_writedata[9:8];
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      manual_q <= 1'b0;
    end else if (ctl_wr && avs_byteenable[0]) begin
      manual_q <= avs_writedata[7];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_miss;
    $rose(fetch_req) && !fetch_hit && !cache_off;
  endsequence
  sequence s_ack_third;
    !fetch_ack [*2] ##1 fetch_ack;
  endsequence
  AST_CACHE_OFF: assert property (ctl_wr && avs_byteenable[2]
    |=> cache_off == $past(avs_writedata[18])) else $error("cache disable missed");
  AST_RWS: assert property (ctl_wr && avs_byteenable[0]
    |=> read_wait_count == $past(avs_writedata[4:1])) else $error("wait count missed");
  AST_HIT_FAST: assert property ($rose(fetch_req) && fetch_hit && !cache_off
    && read_wait_count == 4'h0 |-> fetch_ack) else $error("hit not immediate");
  AST_LP_MISS: assert property (s_miss ##0 (cache_low_power
    && read_wait_count == 4'h0) |-> !fetch_ack ##1 fetch_ack) else $error("lp miss wait");
  AST_WAIT2: assert property (s_miss ##0 (!cache_low_power
    && read_wait_count == 4'h2) |-> s_ack_third) else $error("miss wait wrong");
  AST_SLEEP_CUT: assert property (sleep_enter && sleep_q != 2'h3
    |=> flash_low_power) else $error("no cut on sleep");
  AST_NO_CUT: assert property (sleep_enter && sleep_q == 2'h3
    && !flash_low_power |=> !flash_low_power) else $error("cut while disabled");
  AST_WAKE_EXIT: assert property (sleep_exit && !sleep_enter
    && sleep_q == 2'h1 |=> !flash_low_power) else $error("no wake on exit");
  AST_AUTO_WR: assert property (buf_store && buf_last_word && !manual_q
    |=> auto_write_start && auto_write_addr == $past(buf_store_addr))
    else $error("auto write missed");
  AST_ERR_SET: assert property (flash_fault || locked_region_fault
    || bad_command_fault |=> error_event) else $error("error event missed");
  // The release edge still sees reset in the design, so checking starts one cycle later
  AST_READY: assert property (!reset |=> flash_ready == !$past(ctrl_busy))
    else $error("ready wrong");
  AST_IRQ_CLR: assert property (clr_wr && avs_byteenable[0] |=>
    !(irq_err_enable && $past(avs_writedata[1])) && !(irq_rdy_enable && $past(avs_writedata[0])))
    else $error("enable not cleared");
endmodule // nvc_config_props

bind nvc_config_top nvc_config_props #(.ADDR_W(ADDR_W)) u_props (.*);

// [tb/nvc_fetch_host.sv]
// Purpose: Processor model on the fetch port
// Assumes: go is a one-cycle pulse given only while idle
// Notes: Holds the request until acknowledged, as a stalled core would
`timescale 1ns/10ps
module nvc_fetch_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench control
  input wire logic go,
  input wire logic hit,
  // Fetch port
  input wire logic fetch_ack,
  output logic fetch_req,
  output logic fetch_hit
);
  always_ff @(posedge clk) begin
    if (reset || fetch_ack) begin
      fetch_req <= 1'b0;
    end else if (go) begin
      fetch_req <= 1'b1;
    end
  end
  // Hit toggles while idle so nothing may lean on a stale value
  always_ff @(posedge clk) begin
    fetch_hit <= reset ? 1'b0 : (fetch_req ? fetch_hit : (go ? hit : ~fetch_hit));
  end
endmodule // nvc_fetch_host

// [tb/nvc_config_tb_top.sv]
// Purpose: Self-checking bench for the flash configuration block
// Assumes: Bus answers whenever waitrequest drops, fetch ack after the policy count
// Notes: Reads and fetch latencies are noted in queues and checked by a watcher
`timescale 1ns/10ps
module nvc_config_tb_top;
  import nvc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, go = 1'b0, hit = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf, read_wait_count;
  logic avs_waitrequest, fetch_req, fetch_hit, fetch_ack, cache_off, cache_low_power;
  logic sleep_enter = 1'b0, sleep_exit = 1'b0, buf_store = 1'b0, buf_last_word = 1'b1;
  logic [21:0] buf_store_addr = 22'h0, auto_write_addr;
  logic ctrl_busy = 1'b0, flash_fault = 1'b0, locked_region_fault = 1'b0;
  logic bad_command_fault = 1'b0, flash_low_power, auto_write_start, flash_ready;
  logic error_event, irq_err_enable, irq_rdy_enable;
  int n_mismatch = 0, check_count = 0, seed = 97, lat = 0;
  logic [31:0] rd_q[$];
  int lat_q[$];

  always #2 clk = ~clk;

  nvc_config_top #(.EEPROM_PAGES(12'h0a5), .PAGE_SIZE_CODE(3'h5), .MAIN_PAGES(16'h0400))
    dut (.*);
  nvc_fetch_host u_host (.clk(clk), .reset(reset), .go(go), .hit(hit),
    .fetch_ack(fetch_ack), .fetch_req(fetch_req), .fetch_hit(fetch_hit));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waitrequest is read right after each rising edge, before the design's flops move
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic fetch(input logic h, input int need);
    lat_q.push_back(need);
    @(posedge clk);
    go <= 1'b1;
    hit <= h;
    @(posedge clk);
    go <= 1'b0;
    while (lat_q.size() != 0) @(posedge clk);
  endtask

  task automatic sleep_pulse(input logic ex);
    @(posedge clk);
    sleep_enter <= ~ex;
    sleep_exit <= ex;
    @(posedge clk);
    sleep_enter <= 1'b0;
    sleep_exit <= 1'b0;
    @(negedge clk);
  endtask

  function automatic logic [31:0] ctl(input logic c, input logic [1:0] p,
      input logic [1:0] s, input logic m, input logic [3:0] r);
    return {13'h0, c, p, 6'h0, s, m, 2'h0, r, 1'b0};
  endfunction

  always @(negedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk(avs_readdata, rd_q.pop_front());
    end
    if (fetch_ack === 1'b1) begin
      chk(32'(lat), 32'(lat_q.pop_front()));
      lat = 0;
    end else if (fetch_req === 1'b1) begin
      lat++;
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #40000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic [3:0] r;
    logic [1:0] e;
    int need;
    logic [31:0] g;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(NVC_OFS_CONTROL, 32'h0);
    rd(NVC_OFS_GEOMETRY, 32'h0a55_0400);
    rd(NVC_OFS_IRQ_EN_CLR, 32'h0);
    rd(8'h30, 32'h0);
    bus(1'b1, NVC_OFS_CONTROL, 32'hffff_ffff);
    rd(NVC_OFS_CONTROL, 32'h0004_039e);
    avs_byteenable <= 4'h4;
    bus(1'b1, NVC_OFS_CONTROL, 32'h0);
    avs_byteenable <= 4'hf;
    rd(NVC_OFS_CONTROL, 32'h0000_039e);
    g = 32'($random(seed));
    bus(1'b1, NVC_OFS_GEOMETRY, g);
    rd(NVC_OFS_GEOMETRY, 32'h0a55_0400);
    $display("register access done");
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 3; p++) begin
        for (int h = 0; h < 2; h++) begin
          r = h ? 4'($random(seed)) : (p == 1 ? 4'h0 : 4'h2);
          bus(1'b1, NVC_OFS_CONTROL, ctl(c[0], p[1:0], 2'h3, 1'b0, r));
          @(negedge clk);
          chk(cache_low_power, c == 0 && p == 1);
          need = (p == 2) ? r : ((h && !c) ? 0 : r + (p == 1));
          fetch(h[0], need);
        end
      end
    end
    $display("fetch timing done");
    for (int s = 0; s < 4; s++) begin
      e = (s == 2) ? 2'h1 : s[1:0];
      bus(1'b1, NVC_OFS_CONTROL, ctl(1'b0, 2'h0, s[1:0], 1'b0, 4'h0));
      rd(NVC_OFS_CONTROL, ctl(1'b0, 2'h0, e, 1'b0, 4'h0));
      sleep_pulse(1'b0);
      chk(flash_low_power, e != 2'h3);
      sleep_pulse(1'b1);
      chk(flash_low_power, e == 2'h0);
      fetch(1'b1, 0);
      @(negedge clk);
      chk(flash_low_power, 1'b0);
    end
    $display("sleep power done");
    // Explicit mode, or a store short of the last word, must leave the write unstarted
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, NVC_OFS_CONTROL, ctl(1'b0, 2'h0, 2'h3, m[0], 4'h0));
      @(posedge clk);
      buf_store <= 1'b1;
      buf_last_word <= (m != 2);
      buf_store_addr <= 22'($random(seed));
      @(posedge clk);
      buf_store <= 1'b0;
      @(negedge clk);
      chk(auto_write_start, m == 0);
      chk(auto_write_addr, buf_store_addr);
    end
    $display("page write done");
    bus(1'b1, NVC_OFS_IRQ_EN_SET, 32'h3);
    rd(NVC_OFS_IRQ_EN_CLR, 32'h3);
    bus(1'b1, NVC_OFS_IRQ_EN_CLR, 32'h2);
    rd(NVC_OFS_IRQ_EN_SET, 32'h1);
    bus(1'b1, NVC_OFS_IRQ_EN_CLR, 32'h0);
    rd(NVC_OFS_IRQ_EN_CLR, 32'h1);
    bus(1'b1, NVC_OFS_IRQ_EN_CLR, 32'h1);
    rd(NVC_OFS_IRQ_EN_SET, 32'h0);
    $display("interrupt enables done");
    for (int f = 0; f < 3; f++) begin
      @(posedge clk);
      {bad_command_fault, locked_region_fault, flash_fault} <= 3'h1 << f;
      ctrl_busy <= f[0];
      @(posedge clk);
      {bad_command_fault, locked_region_fault, flash_fault} <= 3'h0;
      @(negedge clk);
      chk(error_event, 1'b1);
      rd(NVC_OFS_IRQ_FLAGS, {30'h0, 1'b1, ~f[0]});
      bus(1'b1, NVC_OFS_IRQ_FLAGS, 32'h2);
      @(negedge clk);
      chk(error_event, 1'b0);
    end
    $display("events done");
    print_verdict();
  end
endmodule // nvc_config_tb_top
